//--- design/usb_host_endpoint_control.sv
// Purpose: host port and endpoint control behind an APB slave
// Assumes: serial engine outside; pins synchronous to clk
// Notes:   one transaction at a time; software starts it via command word
`timescale 1ns/1ns
`include "usb_host_ep_regs.svh"
module usb_host_endpoint_control #(
   parameter int FRAME_CYCLES = `FRAME_CYC
) (
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       srst,
   // apb slave
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [11:0]                paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   // line state and port pins
   input  wire logic                       dpIn,
   input  wire logic                       dmIn,
   input  wire logic                       devDisconnect,
   output logic                            pullDownEn,
   output logic                            slowRate,
   output logic                            busResetDrive,
   output logic                            portActive,
   // serial engine link
   output usb_host_ep_pkg::pkt_req_s       pktReq,
   input  wire usb_host_ep_pkg::pkt_rsp_s  pktRsp,
   // status
   output logic                            xferDone
);
   localparam logic [3:0] PID_OUT   = 4'h1;
   localparam logic [3:0] PID_IN    = 4'h9;
   localparam logic [3:0] PID_SETUP = 4'hD;
   localparam logic [3:0] PID_SOF   = 4'h5;
   localparam logic [3:0] PID_PRE   = 4'hC;
   localparam logic [3:0] PID_ACK   = 4'h2;
   localparam logic [3:0] PID_D0    = 4'h3;
   localparam logic [3:0] PID_D1    = 4'hB;

   // register state
   logic [7:0]  portCtrl_r, epMode_r, auxSetup_r, token_r, rxCtrl_r, txLen_r, txCtrl_r;
   logic [15:0] rxBase_r, txBase_r;
   logic [7:0]  rxLen_r;
   logic        done_r, togOk_r, ok_r;
   logic [10:0] frameNum_r;
   logic [31:0] frameCnt_r;
   logic        sofDue_r;
   logic [15:0] waitCnt_r;
   logic        isIn_r;
   usb_host_ep_pkg::xact_state_e state_r, state_nxt;

   // apb decode; zero-wait answer
   wire        wrEn = psel & penable & pwrite;
   wire        rdEn = psel & ~penable & ~pwrite;  // latched in setup, stands in access
   wire [11:0] ofs  = {paddr[11:2], 2'b00};
   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      hit = (a == {o[9:0], 2'b00});
   endfunction
   wire hPort = hit(ofs, `OFS_PORT_CTRL);
   wire hMode = hit(ofs, `OFS_EP_MODE);
   wire hRxB  = hit(ofs, `OFS_RX_BASE);
   wire hTxB  = hit(ofs, `OFS_TX_BASE);
   wire hAux  = hit(ofs, `OFS_AUX_SETUP);
   wire hTok  = hit(ofs, `OFS_TOKEN);
   wire hRxC  = hit(ofs, `OFS_RX_CTRL);
   wire hTxL  = hit(ofs, `OFS_TX_LEN);
   wire hTxC  = hit(ofs, `OFS_TX_CTRL);
   wire hStat = hit(ofs, `OFS_XFER_STAT);
   wire hRxL  = hit(ofs, `OFS_RX_LEN);
   wire hCmd  = hit(ofs, `OFS_CMD);
   wire mapped = hPort | hMode | hRxB | hTxB | hAux | hTok | hRxC | hTxL | hTxC
               | hStat | hRxL | hCmd;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // readback, reserved bits zero; taken at setup so zero-wait access sees it
   wire [7:0] portRd = {portCtrl_r[`PC_PD_DIS], 1'b0, dpIn, dmIn, 1'b0,
                        portCtrl_r[2:0]};
   always_ff @(posedge clk) begin
      if (srst) begin
         prdata <= 32'h0000_0000;
      end else if (rdEn) begin
         prdata <= hPort ? {24'h00_0000, portRd} :
                   hMode ? {24'h00_0000, epMode_r} :
                   hRxB  ? {16'h0000, rxBase_r} :
                   hTxB  ? {16'h0000, txBase_r} :
                   hAux  ? {24'h00_0000, auxSetup_r} :
                   hTok  ? {24'h00_0000, token_r} :
                   hRxC  ? {24'h00_0000, rxCtrl_r} :
                   hTxL  ? {24'h00_0000, txLen_r} :
                   hTxC  ? {24'h00_0000, txCtrl_r} :
                   hStat ? {29'h0000_0000, ok_r, togOk_r, done_r} :
                   hRxL  ? {24'h00_0000, rxLen_r} : 32'h0000_0000;
      end
   end

   // control bits to pins
   wire portEn = portCtrl_r[`PC_PORT_EN];
   assign pullDownEn    = ~portCtrl_r[`PC_PD_DIS];
   assign slowRate      = portCtrl_r[`PC_SLOW];
   assign busResetDrive = portCtrl_r[`PC_BUS_RST];
   assign portActive    = portEn;

   // buffer addresses
   logic [15:0] txAddr, rxAddr;
   logic        txUsed, rxUsed;
   host_buf_addr uTxBuf (
      .base   (txBase_r),
      .enable (epMode_r[`EM_TX_EN]),
      .dbl    (epMode_r[`EM_TX_DBL]),
      .tog    (txCtrl_r[`TC_TOG]),
      .addr   (txAddr),
      .used   (txUsed)
   );
   host_buf_addr uRxBuf (
      .base   (rxBase_r),
      .enable (epMode_r[`EM_RX_EN]),
      .dbl    (epMode_r[`EM_RX_DBL]),
      .tog    (rxCtrl_r[`RC_TOG]),
      .addr   (rxAddr),
      .used   (rxUsed)
   );

   // transaction decode
   wire [3:0] tokPid = token_r[7:4];
   wire       isOut  = (tokPid == PID_OUT) | (tokPid == PID_SETUP);
   wire       isIn   = (tokPid == PID_IN);
   wire       startReq = wrEn & hCmd & pwdata[`CMD_START];
   wire       sofReq   = wrEn & hCmd & pwdata[`CMD_SOF];
   wire       needPre  = auxSetup_r[`AS_PRE_EN];
   wire       timeout  = (waitCnt_r == `PKT_TIMEOUT_CYC);
   wire       rxTogOk  = pktRsp.dataTog == rxCtrl_r[`RC_TOG];
   wire       expectHand = ~txCtrl_r[`TC_NORES];
   wire       outGood  = expectHand ? (pktRsp.gotHand) : 1'b1;
   wire       waitEnd  = pktRsp.done | timeout;
   wire       xactOk   = isIn_r ? (pktRsp.gotData & rxTogOk) : outGood;
   wire       ackReq   = isIn_r & ~rxCtrl_r[`RC_NORES] & ok_r;

   // state sequencing; idle whenever port is off
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         usb_host_ep_pkg::ST_IDLE: begin
            if (portEn & sofDue_r)
               state_nxt = usb_host_ep_pkg::ST_SOF;
            else if (portEn & startReq & ((isOut & txUsed) | (isIn & rxUsed)))
               state_nxt = needPre ? usb_host_ep_pkg::ST_PRE : usb_host_ep_pkg::ST_TOKEN;
         end
         usb_host_ep_pkg::ST_PRE:   if (pktRsp.done) state_nxt = usb_host_ep_pkg::ST_TOKEN;
         usb_host_ep_pkg::ST_TOKEN: if (pktRsp.done)
            state_nxt = isIn_r ? usb_host_ep_pkg::ST_WAIT : usb_host_ep_pkg::ST_DATA;
         usb_host_ep_pkg::ST_DATA:  if (pktRsp.done)
            state_nxt = expectHand ? usb_host_ep_pkg::ST_WAIT : usb_host_ep_pkg::ST_DONE;
         usb_host_ep_pkg::ST_WAIT:  if (waitEnd) state_nxt = usb_host_ep_pkg::ST_DONE;
         usb_host_ep_pkg::ST_DONE:  if (!ackReq || pktRsp.done) state_nxt = usb_host_ep_pkg::ST_IDLE;
         usb_host_ep_pkg::ST_SOF:   if (pktRsp.done) state_nxt = usb_host_ep_pkg::ST_IDLE;
         default:                   state_nxt = usb_host_ep_pkg::ST_IDLE;
      endcase
      if (!portEn)
         state_nxt = usb_host_ep_pkg::ST_IDLE;
   end

   // request to serial engine
   wire inPhase = (state_r == usb_host_ep_pkg::ST_WAIT);
   wire inReady = isIn_r & inPhase;
   always_comb begin
      pktReq       = '0;
      pktReq.slow  = portCtrl_r[`PC_SLOW];
      pktReq.endp  = token_r[3:0];
      case (state_r)
         usb_host_ep_pkg::ST_PRE: begin
            pktReq.valid = 1'b1;
            pktReq.kind  = usb_host_ep_pkg::PKT_PRE;
            pktReq.pid   = PID_PRE;
         end
         usb_host_ep_pkg::ST_TOKEN: begin
            pktReq.valid = 1'b1;
            pktReq.kind  = usb_host_ep_pkg::PKT_TOKEN;
            pktReq.pid   = tokPid;
         end
         usb_host_ep_pkg::ST_DATA: begin
            pktReq.valid = 1'b1;
            pktReq.kind  = usb_host_ep_pkg::PKT_DATA;
            pktReq.pid   = txCtrl_r[`TC_TOG] ? PID_D1 : PID_D0;
            pktReq.len   = txLen_r;
            pktReq.addr  = txAddr;
         end
         usb_host_ep_pkg::ST_WAIT: begin
            // engine listens; without a request it would never answer
            pktReq.valid = 1'b1;
            if (isIn_r) begin
               pktReq.kind = usb_host_ep_pkg::PKT_DATA;
               pktReq.pid  = rxCtrl_r[`RC_TOG] ? PID_D1 : PID_D0;
            end else begin
               pktReq.kind = usb_host_ep_pkg::PKT_HAND;
               pktReq.pid  = PID_ACK;
            end
            pktReq.addr  = inReady ? rxAddr : 16'h0000;
         end
         usb_host_ep_pkg::ST_DONE: begin
            // handshake only for in data that arrived in step
            pktReq.valid = ackReq;
            pktReq.kind  = usb_host_ep_pkg::PKT_HAND;
            pktReq.pid   = PID_ACK;
         end
         usb_host_ep_pkg::ST_SOF: begin
            pktReq.valid = 1'b1;
            pktReq.kind  = usb_host_ep_pkg::PKT_TOKEN;
            pktReq.pid   = PID_SOF;
            pktReq.endp  = frameNum_r[3:0];
            pktReq.addr  = {5'h00, frameNum_r};
         end
         default: pktReq.valid = 1'b0;
      endcase
   end

   // frame timer; manual request also counts as due
   always_ff @(posedge clk) begin
      if (srst || !portEn) begin
         frameCnt_r <= 32'h0000_0000;
         sofDue_r   <= 1'b0;
      end else begin
         frameCnt_r <= (frameCnt_r == 32'(FRAME_CYCLES - 1)) ? 32'h0000_0000 : frameCnt_r + 1;
         if ((auxSetup_r[`AS_SOF_EN] && frameCnt_r == 32'(FRAME_CYCLES - 1)) || sofReq)
            sofDue_r <= 1'b1;
         else if (state_r == usb_host_ep_pkg::ST_SOF)
            sofDue_r <= 1'b0;
      end
   end

   // state, response wait counter, frame number
   always_ff @(posedge clk) begin
      if (srst) begin
         state_r    <= usb_host_ep_pkg::ST_IDLE;
         waitCnt_r  <= 16'h0000;
         isIn_r     <= 1'b0;
         frameNum_r <= 11'h000;
      end else begin
         state_r   <= state_nxt;
         // clears once the wait ends, so the count never passes the limit
         waitCnt_r <= (state_r == usb_host_ep_pkg::ST_WAIT && !waitEnd) ?
                      16'(waitCnt_r + 16'h0001) : 16'h0000;
         if (state_r == usb_host_ep_pkg::ST_IDLE)
            isIn_r <= isIn;
         if (state_r == usb_host_ep_pkg::ST_SOF && pktRsp.done)
            frameNum_r <= 11'(frameNum_r + 11'h001);
      end
   end

   // software registers; hardware events win over writes
   wire finish = (state_r == usb_host_ep_pkg::ST_WAIT && waitEnd) ||
                 (state_r == usb_host_ep_pkg::ST_DATA && pktRsp.done && !expectHand);
   wire rxFlip = finish & isIn_r & xactOk & rxCtrl_r[`RC_AUTO];
   wire txFlip = finish & ~isIn_r & xactOk & txCtrl_r[`TC_AUTO];
   always_ff @(posedge clk) begin
      if (srst) begin
         portCtrl_r <= `PORT_CTRL_RST;
         epMode_r   <= 8'h00;
         auxSetup_r <= 8'h00;
         token_r    <= 8'h00;
         rxCtrl_r   <= 8'h00;
         txCtrl_r   <= 8'h00;
         txLen_r    <= 8'h00;
         rxBase_r   <= 16'h0000;
         txBase_r   <= 16'h0000;
      end else begin
         if (wrEn & hPort) portCtrl_r <= {pwdata[7], 4'h0, pwdata[2:0]};
         if (devDisconnect) portCtrl_r[`PC_PORT_EN] <= 1'b0;
         if (wrEn & hMode) epMode_r <= pwdata[7:0] & 8'h59;
         if (wrEn & hAux)  auxSetup_r <= pwdata[7:0] & 8'hC0;
         if (wrEn & hTok)  token_r <= pwdata[7:0];
         if (wrEn & hTxL)  txLen_r <= pwdata[7:0];
         if (wrEn & hRxB)  rxBase_r <= pwdata[15:0];
         if (wrEn & hTxB)  txBase_r <= pwdata[15:0];
         if (wrEn & hRxC)  rxCtrl_r <= pwdata[7:0] & 8'h94;
         if (rxFlip) rxCtrl_r[`RC_TOG] <= ~rxCtrl_r[`RC_TOG];
         if (wrEn & hTxC)  txCtrl_r <= pwdata[7:0] & 8'h51;
         if (txFlip) txCtrl_r[`TC_TOG] <= ~txCtrl_r[`TC_TOG];
      end
   end

   // transfer status; set beats write-one clear
   always_ff @(posedge clk) begin
      if (srst) begin
         done_r  <= 1'b0;
         togOk_r <= 1'b0;
         ok_r    <= 1'b0;
         rxLen_r <= 8'h00;
         xferDone <= 1'b0;
      end else begin
         xferDone <= finish;
         if (finish) begin
            done_r  <= 1'b1;
            ok_r    <= xactOk;
            togOk_r <= isIn_r & pktRsp.gotData & rxTogOk;
            if (isIn_r) rxLen_r <= pktRsp.len;
         end else if (wrEn & hStat & pwdata[`ST_DONE]) begin
            done_r <= 1'b0;
         end
      end
   end

   // checks
   a_pulldown_follows: assert property (@(posedge clk) disable iff (srst)
      pullDownEn == ~portCtrl_r[`PC_PD_DIS]) else $error("pull-down mismatch");
   a_disconnect_clears: assert property (@(posedge clk) disable iff (srst)
      devDisconnect |=> !portActive) else $error("port stays on after disconnect");
   a_idle_when_off: assert property (@(posedge clk) disable iff (srst)
      !portEn |=> !pktReq.valid) else $error("traffic while port off");
   a_done_sets_flag: assert property (@(posedge clk) disable iff (srst)
      finish |=> done_r && xferDone) else $error("done flag not set");
   a_rx_flip: assert property (@(posedge clk) disable iff (srst)
      rxFlip && !(wrEn && hRxC) |=> rxCtrl_r[`RC_TOG] != $past(rxCtrl_r[`RC_TOG]))
      else $error("rx toggle not flipped");
   a_tx_flip: assert property (@(posedge clk) disable iff (srst)
      txFlip && !(wrEn && hTxC) |=> txCtrl_r[`TC_TOG] != $past(txCtrl_r[`TC_TOG]))
      else $error("tx toggle not flipped");
   a_data_pid: assert property (@(posedge clk) disable iff (srst)
      state_r == usb_host_ep_pkg::ST_DATA |->
      pktReq.pid == (txCtrl_r[`TC_TOG] ? PID_D1 : PID_D0)) else $error("wrong data pid");
   a_pre_first: assert property (@(posedge clk) disable iff (srst)
      state_r == usb_host_ep_pkg::ST_IDLE && state_nxt == usb_host_ep_pkg::ST_PRE |-> needPre)
      else $error("preamble without enable");
   a_wait_bounded: assert property (@(posedge clk) disable iff (srst)
      waitCnt_r <= `PKT_TIMEOUT_CYC) else $error("response wait overrun");
   c_out_xact: cover property (@(posedge clk) state_r == usb_host_ep_pkg::ST_DATA ##1
      state_r != usb_host_ep_pkg::ST_DATA);
   c_in_xact: cover property (@(posedge clk) finish && isIn_r);
   c_sof: cover property (@(posedge clk) state_r == usb_host_ep_pkg::ST_SOF);
endmodule

//--- design/usb_host_ep_regs.svh
// Purpose: register offsets, field positions, reset values and timing for host endpoint control
// Assumes: one 32-bit aligned APB word per register
// Notes:   offsets are register indices; the bus byte address is four times the index
`ifndef USB_HOST_EP_REGS_SVH
`define USB_HOST_EP_REGS_SVH

// register indices, kept distinct so no two registers share a bus word
`define OFS_PORT_CTRL   12'h001
`define OFS_EP_MODE     12'h00D
`define OFS_RX_BASE     12'h018
`define OFS_TX_BASE     12'h01C
`define OFS_AUX_SETUP   12'h026
`define OFS_TOKEN       12'h028
`define OFS_RX_CTRL     12'h02A
`define OFS_TX_LEN      12'h02C
`define OFS_TX_CTRL     12'h02E
`define OFS_XFER_STAT   12'h030
`define OFS_RX_LEN      12'h034
`define OFS_CMD         12'h038

`define PC_PD_DIS       7
`define PC_DP_LVL       5
`define PC_DM_LVL       4
`define PC_SLOW         2
`define PC_BUS_RST      1
`define PC_PORT_EN      0
`define EM_TX_EN        6
`define EM_TX_DBL       4
`define EM_RX_EN        3
`define EM_RX_DBL       0
`define AS_PRE_EN       7
`define AS_SOF_EN       6
`define RC_TOG          7
`define RC_AUTO         4
`define RC_NORES        2
`define TC_TOG          6
`define TC_AUTO         4
`define TC_NORES        0
`define ST_DONE         0
`define ST_TOG_OK       1
`define ST_OK           2
`define CMD_START       0
`define CMD_SOF         1

`define PORT_CTRL_RST   8'h80
`define BUF_BYTES       16'h0040
`define ADDR_MASK       16'h7FFC
`define FRAME_US        1000
`define CLK_MHZ         100
`define FRAME_CYC       (`FRAME_US * `CLK_MHZ)
`define PKT_TIMEOUT_CYC 16'h0800

`endif

//--- design/usb_host_ep_pkg.sv
// Purpose: types for host endpoint control
// Assumes: nothing beyond the regs header
// Notes:   packet engine link travels as structs
package usb_host_ep_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_PRE   = 3'b001,
      ST_TOKEN = 3'b011,
      ST_DATA  = 3'b010,
      ST_WAIT  = 3'b110,
      ST_DONE  = 3'b111,
      ST_SOF   = 3'b100
   } xact_state_e;

   typedef enum logic [1:0] {
      PKT_TOKEN = 2'b00,
      PKT_DATA  = 2'b01,
      PKT_HAND  = 2'b10,
      PKT_PRE   = 2'b11
   } pkt_kind_e;

   // request to the serial engine
   typedef struct packed {
      logic        valid;
      pkt_kind_e   kind;
      logic [3:0]  pid;
      logic [3:0]  endp;
      logic [7:0]  len;
      logic [15:0] addr;
      logic        slow;
   } pkt_req_s;

   // answer from the serial engine
   typedef struct packed {
      logic        done;
      logic        gotData;
      logic        gotHand;
      logic        dataTog;
      logic [7:0]  len;
   } pkt_rsp_s;
endpackage

//--- design/host_buf_addr.sv
// Purpose: buffer address for single or double buffered endpoints
// Assumes: base programmed 4-byte aligned
// Notes:   disabled endpoint gives no valid address
`timescale 1ns/1ns
`include "usb_host_ep_regs.svh"
module host_buf_addr (
   // configuration
   input  wire logic [15:0] base,
   input  wire logic        enable,
   input  wire logic        dbl,
   input  wire logic        tog,
   // result
   output logic      [15:0] addr,
   output logic             used
);
   // second half only in double mode with toggle one
   wire        upper = dbl & tog;
   wire [15:0] baseEff = base & `ADDR_MASK;
   assign addr = upper ? 16'((baseEff + `BUF_BYTES) & 16'h7FFF) : baseEff;
   assign used = enable;
endmodule

//--- verification/usb_engine_model.sv
// Purpose: serial engine stand-in for the host endpoint block
// Assumes: one request at a time, answered by a one-cycle done
// Notes:   idle toggle and length flip each cycle, flags stay low, so stale values never pass
`timescale 1ns/1ns
module usb_engine_model (
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      srst,
   // packet link
   input  wire usb_host_ep_pkg::pkt_req_s req,
   output usb_host_ep_pkg::pkt_rsp_s      rsp,
   // data packet returned on receive
   input  wire logic                      inTog,
   input  wire logic [7:0]                inLen
);
   usb_host_ep_pkg::pkt_req_s seen[$];
   usb_host_ep_pkg::pkt_rsp_s r   = '0;
   int                        cnt = 0;
   int                        lim = 1;
   assign rsp = r;
   // answer after a random wait, slow or prompt; design advances on done
   always @(posedge clk) begin
      r <= '{1'b0, 1'b0, 1'b0, ~r.dataTog, ~r.len};
      if (srst)
         cnt <= 0;
      else if (req.valid && !r.done) begin
         cnt <= cnt + 1;
         if (cnt >= lim) begin
            r   <= '{1'b1, 1'b1, 1'b1, inTog, inLen};
            seen.push_back(req);
            cnt <= 0;
            lim <= $urandom_range(3);
         end
      end
   end
endmodule

//--- verification/tb_usb_host_endpoint_control.sv
// Purpose: self-checking bench for host endpoint control
// Assumes: engine model answers every request
// Notes:   every register has a bus word of its own
`timescale 1ns/1ns
`include "usb_host_ep_regs.svh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin badCount++; \
   $display("mismatch %s exp %0h saw %0h", n, e, s); end end
module tb_usb_host_endpoint_control;
   logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
   logic        dpIn = 0, dmIn = 0, devDisconnect = 0, inTog = 0, errq;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rq;
   logic [7:0]  inLen = '0, tl, tok;
   logic [7:0]  pv[2] = '{8'h07, 8'h81};
   logic [15:0] txB, rxB, ea;
   logic        pready, pslverr, pullDownEn, slowRate, busResetDrive, portActive, xferDone;
   usb_host_ep_pkg::pkt_req_s pktReq;
   usb_host_ep_pkg::pkt_rsp_s pktRsp;
   usb_host_ep_pkg::pkt_req_s q;
   int          badCount = 0, checks = 0, n;

   always #5 clk = ~clk;

   usb_host_endpoint_control #(.FRAME_CYCLES(50)) dut (.clk, .srst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .dpIn, .dmIn, .devDisconnect, .pullDownEn,
      .slowRate, .busResetDrive, .portActive, .pktReq, .pktRsp, .xferDone);
   usb_engine_model eng (.clk(clk), .srst(srst), .req(pktReq), .rsp(pktRsp),
      .inTog(inTog), .inLen(inLen));

   // byte address of a register index
   function automatic logic [11:0] w(input logic [11:0] o);
      return {o[9:0], 2'b00};
   endfunction

   // one apb transfer; answer taken at the edge that sees pready high
   task automatic apb(input logic [11:0] a, input logic wr, input logic [15:0] d);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {16'h0000, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      rq      = prdata;
      errq    = pslverr;
      if (n >= 40) badCount++;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // read data stands during the access phase
   task automatic rd(input logic [11:0] a);
      apb(a, 1'b0, 16'h0000);
   endtask

   // clear done, start, wait for the completion pulse
   task automatic go;
      apb(w(`OFS_XFER_STAT), 1'b1, 16'h0001);
      eng.seen.delete();
      apb(w(`OFS_CMD), 1'b1, 16'h0001);
      n = 0;
      while (xferDone !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 3000) badCount++;
      // let a trailing handshake finish before the queue is read
      repeat (8) @(posedge clk);
   endtask

   task automatic testDone;
      $display("checks %0d mismatches %0d", checks, badCount);
      if (badCount == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // watchdog, far beyond the expected run length
   initial begin
      #400000;
      badCount++;
      testDone;
   end

   initial begin
      void'($urandom(96));
      dpIn <= 1'($urandom);
      dmIn <= 1'($urandom);
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      rd(w(`OFS_PORT_CTRL));
      `CHK("portCtrl", {2'b10, dpIn, dmIn, 4'h0}, rq[7:0])
      `CHK("pullDown", 1'b0, pullDownEn)
      rd(w(`OFS_EP_MODE));
      `CHK("epMode", 8'h00, rq[7:0])
      foreach (pv[i]) begin
         apb(w(`OFS_PORT_CTRL), 1'b1, {8'h00, pv[i]});
         `CHK("pins", {~pv[i][7], pv[i][2:0]}, {pullDownEn, slowRate, busResetDrive, portActive})
      end
      devDisconnect <= 1'b1;
      @(posedge clk);
      devDisconnect <= 1'b0;
      rd(w(`OFS_PORT_CTRL));
      `CHK("discon", 2'b00, {rq[0], portActive})
      apb(12'h0F0, 1'b1, 16'h0000);
      `CHK("slverr", 1'b1, errq)
      $display("test port done");
      // port off: a start and frame starts must stay off the bus
      apb(w(`OFS_EP_MODE), 1'b1, 16'h0050);
      apb(w(`OFS_AUX_SETUP), 1'b1, 16'h0040);
      apb(w(`OFS_CMD), 1'b1, 16'h0001);
      repeat (120) @(posedge clk);
      `CHK("idleBus", 0, eng.seen.size())
      apb(w(`OFS_PORT_CTRL), 1'b1, 16'h0081);
      repeat (120) @(posedge clk);
      `CHK("frame", {usb_host_ep_pkg::PKT_TOKEN, 4'h5}, {eng.seen[0].kind, eng.seen[0].pid})
      apb(w(`OFS_AUX_SETUP), 1'b1, 16'h0000);
      repeat (40) @(posedge clk);
      eng.seen.delete();
      apb(w(`OFS_CMD), 1'b1, 16'h0002);
      repeat (20) @(posedge clk);
      `CHK("manualSof", {usb_host_ep_pkg::PKT_TOKEN, 4'h5, 8'h01}, {eng.seen[0].kind, eng.seen[0].pid, 8'(eng.seen.size())})
      $display("test frame done");
      // out: double buffer, toggle one with auto flip, ack expected
      txB = 16'($urandom) & `ADDR_MASK;
      tl  = (8'($urandom) | 8'h50) & 8'hFE;
      tok = 8'h10 | 8'($urandom_range(15));
      apb(w(`OFS_TX_BASE), 1'b1, txB);
      apb(w(`OFS_TX_LEN), 1'b1, {8'h00, tl});
      apb(w(`OFS_TOKEN), 1'b1, {8'h00, tok});
      apb(w(`OFS_TX_CTRL), 1'b1, 16'h0050);
      for (int i = 0; i < 2; i++) begin
         go();
         `CHK("outTok", {usb_host_ep_pkg::PKT_TOKEN, tok}, {eng.seen[0].kind, eng.seen[0].pid, eng.seen[0].endp})
         ea = 16'((txB + (i ? 16'h0000 : `BUF_BYTES)) & 16'h7FFF);
         q  = eng.seen[1];
         `CHK("outData", {i ? 4'h3 : 4'hB, tl, ea}, {q.pid, q.len, q.addr})
         rd(w(`OFS_XFER_STAT));
         `CHK("outDone", 1'b1, rq[0])
      end
      // out with preamble, single buffer, no handshake, no auto flip
      apb(w(`OFS_EP_MODE), 1'b1, 16'h0040);
      apb(w(`OFS_TX_CTRL), 1'b1, 16'h0001);
      apb(w(`OFS_AUX_SETUP), 1'b1, 16'h0080);
      go();
      `CHK("preFirst", {usb_host_ep_pkg::PKT_PRE, 4'hC}, {eng.seen[0].kind, eng.seen[0].pid})
      `CHK("outSingle", {4'h3, txB}, {eng.seen[2].pid, eng.seen[2].addr})
      `CHK("noHand", 3, eng.seen.size())
      rd(w(`OFS_TX_CTRL));
      `CHK("txNoFlip", 8'h01, rq[7:0])
      apb(w(`OFS_AUX_SETUP), 1'b1, 16'h0000);
      $display("test out done");
      // in: double buffer, expect one, auto flip, third packet out of step
      rxB = 16'($urandom) & `ADDR_MASK;
      apb(w(`OFS_RX_BASE), 1'b1, rxB);
      apb(w(`OFS_EP_MODE), 1'b1, 16'h0009);
      apb(w(`OFS_TOKEN), 1'b1, 16'h0093);
      apb(w(`OFS_RX_CTRL), 1'b1, 16'h0090);
      for (int i = 0; i < 3; i++) begin
         inTog <= i == 0;
         inLen <= 8'($urandom_range(64));
         go();
         ea = 16'((rxB + ((i != 1) ? `BUF_BYTES : 16'h0000)) & 16'h7FFF);
         `CHK("inBuf", ea, eng.seen[1].addr)
         if (i < 2) `CHK("inAck", usb_host_ep_pkg::PKT_HAND, eng.seen[2].kind)
         rd(w(`OFS_RX_LEN));
         `CHK("inLen", inLen, rq[7:0])
         rd(w(`OFS_XFER_STAT));
         `CHK("inTogOk", {i < 2, 1'b1}, rq[1:0])
      end
      // in data in step but handshake switched off
      apb(w(`OFS_RX_CTRL), 1'b1, 16'h0004);
      inTog <= 1'b0;
      go();
      `CHK("inNoAck", 2, eng.seen.size())
      $display("test in done");
      testDone;
   end
endmodule
